// File: hdl/fivm_pkg.sv
package fivm_pkg;
    // Register addresses on the parallel host port
    localparam logic [11:0] ADDR_MASK_LOW = 12'h902;
    localparam logic [11:0] ADDR_MASK_HIGH = 12'h903;
    // Register shape and reset values
    localparam int REG_W = 16;
    localparam logic [15:0] MASK_LOW_RST = 16'h0000;
    localparam logic [15:0] MASK_HIGH_RST = 16'h0000;
    // Framer count and per-framer category positions
    localparam int N_FRAMERS = 8;
    localparam int N_CAT = 4;
    localparam int CAT_HDLC = 3;
    localparam int CAT_ELASTIC = 2;
    localparam int CAT_RXLINE = 1;
    localparam int CAT_SYNC = 0;
    // Framers per mask register
    localparam int FR_PER_REG = 4;
endpackage

// File: hdl/fivm_vector_mask.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////
// How it works
// - mask one forces vector status to zero
// - mask zero passes event status unchanged
// - low register bits 11:8 mask framer 2
// - low register bits 7:4 mask framer 1
// - low register bits 3:0 mask framer 0
// - high register bits 15:12 mask framer 7
// - high bits 11,10 mask framer 6 H,E
// - framers 0-2 status gated by low mask
// - framer 7 status gated by high mask
// - low register bits 15:12 mask framer 3
// - high bits 9:0 mask framers 6,5,4
module fivm_vector_mask (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Host register port
    input wire logic hostWr,
    input wire logic hostRd,
    input wire logic [11:0] hostAddr,
    input wire logic [15:0] hostWrData,
    output logic [15:0] hostRdData,
    output logic hostRdHit,
    // Raw vector status per framer, {hdlc,elastic,rxline,sync}
    input wire logic [31:0] rawVecStatus,
    // Gated vector status per framer, same layout
    output logic [31:0] vecStatus,
    // Current mask, same layout, framer 0 in bits 3:0
    output logic [31:0] maskAll
);

////////////////////////////////////////////////////////////////////////////
// Mask storage

// Mask registers, low covers framers 0-3, high 4-7
logic [15:0] maskLow_q; // Framers 3..0, framer 0 in bits 3:0
logic [15:0] maskHigh_q; // Framers 7..4, framer 4 in bits 3:0
// Read-back pipeline, one cycle behind the read strobe
logic [15:0] rdData_q; // Returned word, zero on a miss
logic rdHit_q; // High for one cycle after a mapped read

// Address decode, shared by write and read
// Exact 12-bit match, no aliasing of nearby addresses
function automatic logic isAddr(input logic [11:0] a,
                                input logic [11:0] ref_a);
    return a == ref_a;
endfunction

// Host writes to low mask register
always_ff @(posedge clk_sys) begin
    if (rst) begin
        maskLow_q <= fivm_pkg::MASK_LOW_RST;
    end else if (hostWr && isAddr(hostAddr, fivm_pkg::ADDR_MASK_LOW)) begin
        maskLow_q <= hostWrData;
    end
end

// Host writes to high mask register
always_ff @(posedge clk_sys) begin
    if (rst) begin
        maskHigh_q <= fivm_pkg::MASK_HIGH_RST;
    end else if (hostWr && isAddr(hostAddr, fivm_pkg::ADDR_MASK_HIGH)) begin
        maskHigh_q <= hostWrData;
    end
end

// Registered read-back, zero for other addresses
// A write and a read on one edge: the read returns the old word,
// since both paths sample the registers before the edge updates them
// A miss clears the word, so stale data never lingers on the bus
always_ff @(posedge clk_sys) begin
    if (rst) begin
        // Nothing returned during reset
        rdData_q <= 16'h0000;
        rdHit_q <= 1'b0;
    end else if (hostRd && isAddr(hostAddr, fivm_pkg::ADDR_MASK_LOW)) begin
        rdData_q <= maskLow_q;
        rdHit_q <= 1'b1;
    end else if (hostRd && isAddr(hostAddr, fivm_pkg::ADDR_MASK_HIGH)) begin
        rdData_q <= maskHigh_q;
        rdHit_q <= 1'b1;
    end else begin
        rdData_q <= 16'h0000;
        rdHit_q <= 1'b0;
    end
end

assign hostRdData = rdData_q;
assign hostRdHit = rdHit_q;

////////////////////////////////////////////////////////////////////////////
// Per-framer gating

// Framer f uses nibble f of the concatenated masks
assign maskAll = {maskHigh_q, maskLow_q};

// One gate per framer, four categories each; the gating is
// combinational, so a mask write shows on the next cycle's status
// and a raw event passes in the cycle it arrives
genvar gf;
generate
    for (gf = 0; gf < fivm_pkg::N_FRAMERS; gf++) begin : g_fr
        // Nibble: bit3 HDLC, bit2 elastic, bit1 rx line, bit0 sync
        assign vecStatus[gf*4 +: 4] =
            rawVecStatus[gf*4 +: 4] & ~maskAll[gf*4 +: 4];
    end
endgenerate
// Framers 0-3 from low register
// Framers 4-7 from high register

////////////////////////////////////////////////////////////////////////////
// Checks

// Masked bits never reach the status outputs
mask_forces_zero_a: assert property (@(posedge clk_sys)
    disable iff (rst) (vecStatus & maskAll) == 32'h0000_0000)
    else $error("masked status bit is active");

// Unmasked bits follow their raw source in the same cycle
unmask_passes_a: assert property (@(posedge clk_sys)
    disable iff (rst)
    (vecStatus & ~maskAll) == (rawVecStatus & ~maskAll))
    else $error("unmasked status differs from raw");

// Low register bits 11:8 land in the framer 2 nibble
fr2_nibble_a: assert property (@(posedge clk_sys) disable iff (rst)
    hostWr && hostAddr == fivm_pkg::ADDR_MASK_LOW |=>
    maskAll[11:8] == $past(hostWrData[11:8]))
    else $error("framer 2 mask not in low bits 11:8");

// Low register bit 7 silences framer 1 HDLC status
fr1_nibble_a: assert property (@(posedge clk_sys) disable iff (rst)
    hostWr && hostAddr == fivm_pkg::ADDR_MASK_LOW && hostWrData[7] |=>
    !vecStatus[7])
    else $error("framer 1 hdlc not masked by bit 7");

// Low register bits 3:0 land in the framer 0 nibble
fr0_nibble_a: assert property (@(posedge clk_sys) disable iff (rst)
    hostWr && hostAddr == fivm_pkg::ADDR_MASK_LOW |=>
    maskAll[3:0] == $past(hostWrData[3:0]))
    else $error("framer 0 mask not in low bits 3:0");

// High register bits 15:12 land in the framer 7 nibble
fr7_nibble_a: assert property (@(posedge clk_sys) disable iff (rst)
    hostWr && hostAddr == fivm_pkg::ADDR_MASK_HIGH |=>
    maskAll[31:28] == $past(hostWrData[15:12]))
    else $error("framer 7 mask not in high bits 15:12");

// High register bit 11 silences framer 6 HDLC status
fr6_hdlc_a: assert property (@(posedge clk_sys) disable iff (rst)
    hostWr && hostAddr == fivm_pkg::ADDR_MASK_HIGH && hostWrData[11] |=>
    !vecStatus[27])
    else $error("framer 6 hdlc not masked by high bit 11");

// High register bit 10 silences framer 6 elastic status
fr6_elastic_a: assert property (@(posedge clk_sys) disable iff (rst)
    hostWr && hostAddr == fivm_pkg::ADDR_MASK_HIGH && hostWrData[10] |=>
    !vecStatus[26])
    else $error("framer 6 elastic not masked by high bit 10");

// Framers 0-2 status gated only by the low register
low_gating_a: assert property (@(posedge clk_sys) disable iff (rst)
    vecStatus[11:0] == (rawVecStatus[11:0] & ~maskLow_q[11:0]))
    else $error("framers 0-2 status not gated by low mask");

// Framer 7 rx line, elastic and sync gated by the high register
fr7_gating_a: assert property (@(posedge clk_sys) disable iff (rst)
    vecStatus[30:28] == (rawVecStatus[30:28] & ~maskHigh_q[14:12]))
    else $error("framer 7 status not gated by high mask");

// Low register bits 15:12 land in the framer 3 nibble
fr3_nibble_a: assert property (@(posedge clk_sys) disable iff (rst)
    hostWr && hostAddr == fivm_pkg::ADDR_MASK_LOW |=>
    maskAll[15:12] == $past(hostWrData[15:12]))
    else $error("framer 3 mask not in low bits 15:12");

// High register bits 9:0 land in framers 6, 5 and 4
fr456_bits_a: assert property (@(posedge clk_sys) disable iff (rst)
    hostWr && hostAddr == fivm_pkg::ADDR_MASK_HIGH |=>
    maskAll[25:16] == $past(hostWrData[9:0]))
    else $error("framers 4-6 mask not in high bits 9:0");

// High register reads back its stored value a cycle later
mask_readback_a: assert property (@(posedge clk_sys)
    disable iff (rst)
    hostRd && hostAddr == fivm_pkg::ADDR_MASK_HIGH |=>
    hostRdHit && hostRdData == $past(maskHigh_q))
    else $error("high mask readback wrong");

// Low register reads back its stored value a cycle later
low_readback_a: assert property (@(posedge clk_sys)
    disable iff (rst)
    hostRd && hostAddr == fivm_pkg::ADDR_MASK_LOW |=>
    hostRdHit && hostRdData == $past(maskLow_q))
    else $error("low mask readback wrong");

// Other addresses read as zero without a hit
unmapped_read_a: assert property (@(posedge clk_sys)
    disable iff (rst)
    hostRd && hostAddr != fivm_pkg::ADDR_MASK_LOW &&
    hostAddr != fivm_pkg::ADDR_MASK_HIGH |=>
    !hostRdHit && hostRdData == 16'h0000)
    else $error("unmapped read not zero");

// Reset clears every mask bit on the next cycle
reset_clear_a: assert property (@(posedge clk_sys)
    rst |=> maskAll == 32'h0000_0000)
    else $error("masks not cleared by reset");

// Main scenarios worth seeing
low_write_c: cover property (@(posedge clk_sys)
    hostWr && hostAddr == fivm_pkg::ADDR_MASK_LOW);
high_read_c: cover property (@(posedge clk_sys)
    hostRd && hostAddr == fivm_pkg::ADDR_MASK_HIGH);
low_read_c: cover property (@(posedge clk_sys)
    hostRd && hostAddr == fivm_pkg::ADDR_MASK_LOW);
unmapped_read_c: cover property (@(posedge clk_sys)
    hostRd && hostAddr != fivm_pkg::ADDR_MASK_LOW &&
    hostAddr != fivm_pkg::ADDR_MASK_HIGH);
event_masked_c: cover property (@(posedge clk_sys)
    (rawVecStatus & maskAll) != 32'h0000_0000);

endmodule

// File: verif/fivm_host_model.sv
`timescale 1ns/1ps
module fivm_host_model (
    // Clock
    input wire logic clk_sys,
    // Host register port
    output logic hostWr,
    output logic hostRd,
    output logic [11:0] hostAddr,
    output logic [15:0] hostWrData
);
    // Idle bus at time zero
    initial begin
        hostWr = 1'b0;
        hostRd = 1'b0;
        hostAddr = 12'h000;
        hostWrData = 16'h0000;
    end
    // One-cycle access; released data inverted so it never looks valid
    task automatic access(input logic w, input logic [11:0] a,
                          input logic [15:0] d);
        @(posedge clk_sys);
        hostWr <= w;
        hostRd <= !w;
        hostAddr <= a;
        hostWrData <= d;
        @(posedge clk_sys);
        hostWr <= 1'b0;
        hostRd <= 1'b0;
        hostWrData <= ~d;
        #1;
    endtask
endmodule

// File: verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic clk_sys, rst, hostWr, hostRd, hostRdHit;
    logic [11:0] hostAddr;
    logic [15:0] hostWrData, hostRdData;
    logic [31:0] rawVecStatus, vecStatus, maskAll;
    int n_errors = 0;
    int num_checks = 0;
    // Free-running system clock
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    fivm_host_model host_u (.clk_sys(clk_sys), .hostWr(hostWr),
        .hostRd(hostRd), .hostAddr(hostAddr), .hostWrData(hostWrData));
    fivm_vector_mask dut_u (.clk_sys(clk_sys), .rst(rst), .hostWr(hostWr),
        .hostRd(hostRd), .hostAddr(hostAddr), .hostWrData(hostWrData),
        .hostRdData(hostRdData), .hostRdHit(hostRdHit),
        .rawVecStatus(rawVecStatus), .vecStatus(vecStatus),
        .maskAll(maskAll));
    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic complete_run;
        $display("errors=%0d checks=%0d", n_errors, num_checks);
        if (n_errors == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // Masks clear and status passes after reset
    task automatic t_reset;
        @(posedge clk_sys);
        rawVecStatus <= 32'h5A5AC3C3;
        #1;
        chk(maskAll, 32'h0);
        chk(vecStatus, 32'h5A5AC3C3);
        $display("reset test done");
    endtask
    // Walk one mask bit through both registers
    task automatic t_map;
        @(posedge clk_sys);
        rawVecStatus <= 32'hFFFFFFFF;
        for (int i = 0; i < 16; i++) begin
            host_u.access(1'b1, fivm_pkg::ADDR_MASK_LOW, 16'h1 << i);
            chk(maskAll, 32'h1 << i);
            chk(vecStatus, ~(32'h1 << i));
        end
        host_u.access(1'b1, fivm_pkg::ADDR_MASK_LOW, 16'h0000);
        chk(vecStatus, 32'hFFFFFFFF);
        for (int i = 0; i < 16; i++) begin
            host_u.access(1'b1, fivm_pkg::ADDR_MASK_HIGH, 16'h1 << i);
            chk(maskAll, 32'h1 << (16 + i));
            chk(vecStatus, ~(32'h1 << (16 + i)));
        end
        host_u.access(1'b1, fivm_pkg::ADDR_MASK_HIGH, 16'h0000);
        chk(maskAll, 32'h0);
        $display("map test done");
    endtask
    // Readback, unmapped read, mid-run reset
    task automatic t_read;
        @(posedge clk_sys);
        rawVecStatus <= 32'h5A5AA5A5;
        host_u.access(1'b1, fivm_pkg::ADDR_MASK_LOW, 16'hF00F);
        host_u.access(1'b1, fivm_pkg::ADDR_MASK_HIGH, 16'h0C30);
        chk(vecStatus, 32'h5A5AA5A5 & ~32'h0C30F00F);
        host_u.access(1'b0, fivm_pkg::ADDR_MASK_LOW, 16'h0000);
        chk({hostRdHit, hostRdData}, 17'h1F00F);
        host_u.access(1'b0, fivm_pkg::ADDR_MASK_HIGH, 16'h0000);
        chk({hostRdHit, hostRdData}, 17'h10C30);
        host_u.access(1'b0, fivm_pkg::ADDR_MASK_HIGH + 12'h001, 16'h0000);
        chk({hostRdHit, hostRdData}, 17'h0);
        @(posedge clk_sys);
        rst <= 1'b1;
        @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        #1;
        chk(maskAll, 32'h0);
        chk(vecStatus, 32'h5A5AA5A5);
        $display("read test done");
    endtask
    // Watchdog
    initial begin
        #100000;
        n_errors++;
        complete_run();
    end
    // Main sequence
    initial begin
        rst = 1'b1;
        rawVecStatus = 32'h0;
        repeat (6) @(posedge clk_sys);
        rst <= 1'b0;
        t_reset();
        t_map();
        t_read();
        complete_run();
    end
endmodule
